// file: logic/rpsel_pkg.sv
// Purpose: Shared constants of the remappable pin select block.
// Assumes: APB slave with 32-bit data, one aligned word per register.
// Notes: Selector registers are 16 bits wide and sit in the low half of the word.
package rpsel_pkg;

    // --------------------------------------------------------------
    // Sizes
    // --------------------------------------------------------------
    localparam int FIELD_W = 6;
    localparam int PIN_COUNT = 64;
    localparam int PERIPH_COUNT = 64;
    localparam int REG_W = 16;
    localparam int NUM_REGS = 6;
    localparam int NUM_IN_REGS = 4;
    localparam int NUM_IN_SEL = 8;
    localparam int NUM_OUT_SEL = 4;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int IDX_W = 3;

    // --------------------------------------------------------------
    // Register map (byte address = index * 4)
    // --------------------------------------------------------------
    localparam logic [IDX_W-1:0] CAPTURE34_INPUT_SELECT_IDX = 3'h0;
    localparam logic [IDX_W-1:0] CAPTURE56_INPUT_SELECT_IDX = 3'h1;
    localparam logic [IDX_W-1:0] UART_FOUR_INPUT_SELECT_IDX = 3'h2;
    localparam logic [IDX_W-1:0] SPI_THREE_INPUT_SELECT_IDX = 3'h3;
    localparam logic [IDX_W-1:0] PINS_20_21_OUTPUT_SELECT_IDX = 3'h4;
    localparam logic [IDX_W-1:0] PINS_22_23_OUTPUT_SELECT_IDX = 3'h5;
    localparam int IDX_LSB = 2;

    // --------------------------------------------------------------
    // Field layout and reset values
    // --------------------------------------------------------------
    localparam int HI_FIELD_LSB = 8;
    localparam int LO_FIELD_LSB = 0;
    localparam logic [REG_W-1:0] IMPL_MASK = 16'h3F3F;
    localparam logic [REG_W-1:0] RST_IN_SEL = 16'h3F3F;
    localparam logic [REG_W-1:0] RST_OUT_SEL = 16'h0000;
    localparam logic [FIELD_W-1:0] IN_UNASSIGNED = 6'h3F;
    localparam logic [FIELD_W-1:0] OUT_NULL = 6'h00;
    localparam logic IN_IDLE_LEVEL = 1'b0;

endpackage

// file: logic/rpsel_in_mux.sv
// Purpose: Picks one synchronised pin for one peripheral input.
// Assumes: Pins are already in the pclk domain.
// Notes: The all-ones code leaves the input unassigned at its idle level.
module rpsel_in_mux (
    // Pins and selector
    input wire logic [rpsel_pkg::PIN_COUNT-1:0] pins,
    input wire logic [rpsel_pkg::FIELD_W-1:0] sel,
    // Peripheral input
    output logic y
);

    // --------------------------------------------------------------
    // Selection
    // --------------------------------------------------------------
    // Unassigned code wins over the pin of the same number
    wire unassigned = (sel == rpsel_pkg::IN_UNASSIGNED);
    assign y = unassigned ? rpsel_pkg::IN_IDLE_LEVEL : pins[sel];

endmodule

// file: logic/rpsel_out_mux.sv
// Purpose: Picks one numbered peripheral output for one remappable pin.
// Assumes: Peripheral outputs come from pclk logic.
// Notes: Number zero means no peripheral, so the pin is not driven.
module rpsel_out_mux (
    // Peripheral outputs and selector
    input wire logic [rpsel_pkg::PERIPH_COUNT-1:0] periph,
    input wire logic [rpsel_pkg::FIELD_W-1:0] sel,
    // Pin drive
    output logic val,
    output logic drive
);

    // --------------------------------------------------------------
    // Selection
    // --------------------------------------------------------------
    // Undriven pin still shows a defined low on its data line
    assign drive = (sel != rpsel_pkg::OUT_NULL);
    assign val = drive ? periph[sel] : 1'b0;

endmodule

// file: logic/rpsel_top.sv
// Purpose: Remappable pin select: pins to peripheral inputs, peripheral outputs to pins 20-23.
// Assumes: pclk at 40 MHz, async active-low presetn, APB with one wait-free registered answer.
// Notes: Everything freezes while ce is low, including a pending APB answer.
//
// The APB slave port and the placing of the registers were chosen for this implementation.
module rpsel_top (
    // Clock, reset, enable
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [rpsel_pkg::ADDR_W-1:0] paddr,
    input wire logic [rpsel_pkg::DATA_W-1:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [rpsel_pkg::DATA_W-1:0] prdata,
    output logic pready,
    output logic pslverr,
    // Remappable pins, asynchronous to pclk
    input wire logic [rpsel_pkg::PIN_COUNT-1:0] remappable_pin,
    // Numbered peripheral outputs, same clock
    input wire logic [rpsel_pkg::PERIPH_COUNT-1:0] periph_out,
    // Peripheral inputs
    output logic capture_channel_three,
    output logic capture_channel_four,
    output logic capture_channel_five,
    output logic capture_channel_six,
    output logic uart_four_receive,
    output logic uart_four_clear_to_send,
    output logic spi_three_data_in,
    output logic spi_three_clock_in,
    // Pins 20 to 23, bit 0 is pin 20
    output logic [3:0] remap_pin_out,
    output logic [3:0] remap_pin_oe_n
);

    // --------------------------------------------------------------
    // Storage
    // --------------------------------------------------------------
    logic [rpsel_pkg::REG_W-1:0] reg_q [0:rpsel_pkg::NUM_REGS-1];
    logic [rpsel_pkg::PIN_COUNT-1:0] pin_s1_q;
    logic [rpsel_pkg::PIN_COUNT-1:0] pin_s2_q;
    logic [rpsel_pkg::NUM_IN_SEL-1:0] in_q;
    logic [rpsel_pkg::NUM_IN_SEL-1:0] in_d;
    logic [rpsel_pkg::NUM_OUT_SEL-1:0] out_q;
    logic [rpsel_pkg::NUM_OUT_SEL-1:0] out_d;
    logic [rpsel_pkg::NUM_OUT_SEL-1:0] oe_n_q;
    logic [rpsel_pkg::NUM_OUT_SEL-1:0] drive_d;
    logic [rpsel_pkg::DATA_W-1:0] prdata_q;
    logic pready_q;
    logic pslverr_q;
    logic [rpsel_pkg::FIELD_W-1:0] in_sel [0:rpsel_pkg::NUM_IN_SEL-1];
    logic [rpsel_pkg::FIELD_W-1:0] out_sel [0:rpsel_pkg::NUM_OUT_SEL-1];

    // --------------------------------------------------------------
    // APB decode
    // --------------------------------------------------------------
    // Registers sit on word boundaries; anything else is refused
    wire [rpsel_pkg::IDX_W-1:0] idx = paddr[rpsel_pkg::IDX_LSB +: rpsel_pkg::IDX_W];
    wire aligned = (paddr[rpsel_pkg::IDX_LSB-1:0] == 2'h0);
    wire upper_zero = (paddr[rpsel_pkg::ADDR_W-1:rpsel_pkg::IDX_LSB+rpsel_pkg::IDX_W] == 3'h0);
    wire in_range = (idx <= rpsel_pkg::PINS_22_23_OUTPUT_SELECT_IDX);
    wire hit = aligned && upper_zero && in_range;
    wire [rpsel_pkg::IDX_W-1:0] safe_idx = hit ? idx : rpsel_pkg::CAPTURE34_INPUT_SELECT_IDX;
    wire setup_ph = psel && !penable && !pready_q;
    wire access_done = psel && penable && pready_q;
    wire wr_en = access_done && pwrite && hit;

    // Byte enables cover only the two low lanes that hold the register
    wire [rpsel_pkg::REG_W-1:0] strb_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
    wire [rpsel_pkg::REG_W-1:0] merged = (reg_q[safe_idx] & ~strb_mask) | (pwdata[rpsel_pkg::REG_W-1:0] & strb_mask);
    wire [rpsel_pkg::REG_W-1:0] reg_d = merged & rpsel_pkg::IMPL_MASK;
    wire [rpsel_pkg::DATA_W-1:0] rd_val = hit ? {16'h0000, reg_q[safe_idx]} : 32'h0000_0000;

    // --------------------------------------------------------------
    // Selector registers
    // --------------------------------------------------------------
    // Reset loads constants only; write lands at the access edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < rpsel_pkg::NUM_REGS; i++) begin
                reg_q[i] <= (i < rpsel_pkg::NUM_IN_REGS) ? rpsel_pkg::RST_IN_SEL : rpsel_pkg::RST_OUT_SEL;
            end
        end else if (ce && wr_en) begin
            reg_q[safe_idx] <= reg_d;
        end
    end

    // --------------------------------------------------------------
    // APB answer
    // --------------------------------------------------------------
    // Answer prepared in setup so every bus output leaves a flop
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0000_0000;
        end else if (ce) begin
            if (setup_ph) begin
                pready_q <= 1'b1;
                pslverr_q <= !hit;
                prdata_q <= pwrite ? 32'h0000_0000 : rd_val;
            end else if (access_done) begin
                pready_q <= 1'b0;
                pslverr_q <= 1'b0;
                prdata_q <= 32'h0000_0000;
            end
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;

    // --------------------------------------------------------------
    // Pin synchroniser
    // --------------------------------------------------------------
    // Only the second stage feeds the input selectors
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pin_s1_q <= 64'h0000_0000_0000_0000;
            pin_s2_q <= 64'h0000_0000_0000_0000;
        end else if (ce) begin
            pin_s1_q <= remappable_pin;
            pin_s2_q <= pin_s1_q;
        end
    end

    // --------------------------------------------------------------
    // Input selectors
    // --------------------------------------------------------------
    // Even index takes the low field, odd index the high field
    for (genvar k = 0; k < rpsel_pkg::NUM_IN_SEL; k++) begin : g_in
        localparam int R = k / 2;
        localparam int L = (k % 2 == 1) ? rpsel_pkg::HI_FIELD_LSB : rpsel_pkg::LO_FIELD_LSB;
        assign in_sel[k] = reg_q[R][L +: rpsel_pkg::FIELD_W];
        rpsel_in_mux u_in (
            .pins(pin_s2_q),
            .sel(in_sel[k]),
            .y(in_d[k])
        );
    end

    // --------------------------------------------------------------
    // Output selectors
    // --------------------------------------------------------------
    // Pin 20 + k follows register four plus k / 2
    for (genvar k = 0; k < rpsel_pkg::NUM_OUT_SEL; k++) begin : g_out
        localparam int R = rpsel_pkg::NUM_IN_REGS + k / 2;
        localparam int L = (k % 2 == 1) ? rpsel_pkg::HI_FIELD_LSB : rpsel_pkg::LO_FIELD_LSB;
        assign out_sel[k] = reg_q[R][L +: rpsel_pkg::FIELD_W];
        rpsel_out_mux u_out (
            .periph(periph_out),
            .sel(out_sel[k]),
            .val(out_d[k]),
            .drive(drive_d[k])
        );
    end

    // --------------------------------------------------------------
    // Registered routing
    // --------------------------------------------------------------
    // One flop stage keeps all outputs glitch free at a cycle of latency
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            in_q <= 8'h00;
            out_q <= 4'h0;
            oe_n_q <= 4'hF;
        end else if (ce) begin
            in_q <= in_d;
            out_q <= out_d;
            oe_n_q <= ~drive_d;
        end
    end

    // Named peripheral inputs and pin drives
    assign capture_channel_three = in_q[0];
    assign capture_channel_four = in_q[1];
    assign capture_channel_five = in_q[2];
    assign capture_channel_six = in_q[3];
    assign uart_four_receive = in_q[4];
    assign uart_four_clear_to_send = in_q[5];
    assign spi_three_data_in = in_q[6];
    assign spi_three_clock_in = in_q[7];
    assign remap_pin_out = out_q;
    assign remap_pin_oe_n = oe_n_q;

    // --------------------------------------------------------------
    // Assertions
    // --------------------------------------------------------------
    capture3_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && reg_q[0][5:0] != rpsel_pkg::IN_UNASSIGNED)
        |=> capture_channel_three == $past(pin_s2_q[reg_q[0][5:0]]))
        else $error("capture three not following selected pin");

    capture4_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && reg_q[0][13:8] != rpsel_pkg::IN_UNASSIGNED)
        |=> capture_channel_four == $past(pin_s2_q[reg_q[0][13:8]]))
        else $error("capture four not following selected pin");

    capture6_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && reg_q[1][13:8] != rpsel_pkg::IN_UNASSIGNED)
        |=> capture_channel_six == $past(pin_s2_q[reg_q[1][13:8]]))
        else $error("capture six not following selected pin");

    uart_cts_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && reg_q[2][13:8] != rpsel_pkg::IN_UNASSIGNED)
        |=> uart_four_clear_to_send == $past(pin_s2_q[reg_q[2][13:8]]))
        else $error("uart four cts not following selected pin");

    spi_clock_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && reg_q[3][13:8] != rpsel_pkg::IN_UNASSIGNED)
        |=> spi_three_clock_in == $past(pin_s2_q[reg_q[3][13:8]]))
        else $error("spi three clock not following selected pin");

    pin21_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> (remap_pin_oe_n[1] == ($past(reg_q[4][13:8]) == rpsel_pkg::OUT_NULL))
        && (remap_pin_oe_n[1] || remap_pin_out[1] == $past(periph_out[reg_q[4][13:8]])))
        else $error("pin 21 drive does not match its selector");

    pin22_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> (remap_pin_oe_n[2] == ($past(reg_q[5][5:0]) == rpsel_pkg::OUT_NULL))
        && (remap_pin_oe_n[2] || remap_pin_out[2] == $past(periph_out[reg_q[5][5:0]])))
        else $error("pin 22 drive does not match its selector");

    reserved_read_a: assert property (@(posedge pclk) disable iff (!presetn)
        pready_q |-> (prdata_q[31:14] == 18'h00000) && (prdata_q[7:6] == 2'h0))
        else $error("unimplemented bits read as nonzero");

    reset_value_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn) |-> reg_q[0] == rpsel_pkg::RST_IN_SEL && reg_q[1] == rpsel_pkg::RST_IN_SEL
        && reg_q[2] == rpsel_pkg::RST_IN_SEL && reg_q[3] == rpsel_pkg::RST_IN_SEL
        && reg_q[4] == rpsel_pkg::RST_OUT_SEL && reg_q[5] == rpsel_pkg::RST_OUT_SEL)
        else $error("selector reset value wrong");

    write_lands_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && wr_en && pstrb[1:0] == 2'h3) |=> reg_q[$past(safe_idx)] == ($past(pwdata[15:0]) & rpsel_pkg::IMPL_MASK))
        else $error("register write did not land");

    answer_pulse_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && setup_ph) |=> pready_q ##1 (!pready_q || !ce))
        else $error("apb answer not a single cycle");

    // --------------------------------------------------------------
    // Remaining routes, answers and freeze
    // --------------------------------------------------------------
    // Low field of the second capture register
    capture5_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && in_sel[2] != rpsel_pkg::IN_UNASSIGNED)
        |=> capture_channel_five == $past(pin_s2_q[in_sel[2]]))
        else $error("capture five not following selected pin");

    // Receive line of the fourth serial port
    uart_rx_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && in_sel[4] != rpsel_pkg::IN_UNASSIGNED)
        |=> uart_four_receive == $past(pin_s2_q[in_sel[4]]))
        else $error("uart four rx not following selected pin");

    // Data line of the third SPI
    spi_data_route_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && in_sel[6] != rpsel_pkg::IN_UNASSIGNED)
        |=> spi_three_data_in == $past(pin_s2_q[in_sel[6]]))
        else $error("spi three data not following selected pin");

    // Pin 20 enable and level follow the low field
    pin20_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> (remap_pin_oe_n[0] == ($past(out_sel[0]) == rpsel_pkg::OUT_NULL))
        && (remap_pin_oe_n[0] || remap_pin_out[0] == $past(periph_out[out_sel[0]])))
        else $error("pin 20 drive does not match its selector");

    // Pin 23 enable and level follow the high field
    pin23_drive_a: assert property (@(posedge pclk) disable iff (!presetn)
        ce |=> (remap_pin_oe_n[3] == ($past(out_sel[3]) == rpsel_pkg::OUT_NULL))
        && (remap_pin_oe_n[3] || remap_pin_out[3] == $past(periph_out[out_sel[3]])))
        else $error("pin 23 drive does not match its selector");

    // Unassigned code must give the idle level, never pin 63
    unassigned_idle_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && in_sel[1] == rpsel_pkg::IN_UNASSIGNED)
        |=> capture_channel_four == rpsel_pkg::IN_IDLE_LEVEL)
        else $error("unassigned capture four not at idle level");

    // Refused address flags an error and leaks no data
    refused_answer_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && setup_ph && !hit)
        |=> pslverr_q && prdata_q == 32'h0000_0000)
        else $error("refused access answered without error");

    // Stored reserved bits stay zero after any write
    reserved_store_a: assert property (@(posedge pclk) disable iff (!presetn)
        (ce && wr_en)
        |=> (reg_q[$past(safe_idx)] & ~rpsel_pkg::IMPL_MASK) == 16'h0000)
        else $error("unimplemented bits stored by a write");

    // Reset leaves every route quiet and no pin driven
    reset_outputs_a: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(presetn)
        |-> in_q == '0 && out_q == '0 && oe_n_q == '1 && !pready_q)
        else $error("outputs not quiet after reset");

    // Enable low must hold every routing flop and the pready flop
    ce_freeze_a: assert property (@(posedge pclk) disable iff (!presetn)
        !ce
        |=> $stable(in_q) && $stable(out_q) && $stable(oe_n_q) && $stable(pready_q))
        else $error("state moved while clock enable low");

endmodule

// file: tb/rpsel_far_model.sv
// Purpose: Far side of the pin select block: device pins and numbered peripheral outputs.
// Assumes: One pin and one peripheral output are high at a time, chosen by the bench.
// Notes: Levels change just after a rising edge, as real pclk-domain sources would.
module rpsel_far_model (
    // Clock
    input wire logic pclk,
    // Choice of the active pin and peripheral
    input wire logic [5:0] hot_pin,
    input wire logic [5:0] hot_periph,
    // Pin levels and peripheral outputs
    output logic [63:0] remappable_pin,
    output logic [63:0] periph_out
);
    timeunit 1ns;
    timeprecision 100ps;

    // One-hot sources, so a wrong route shows as a wrong bit
    always @(posedge pclk) begin
        remappable_pin <= 64'h0000_0000_0000_0001 << hot_pin;
        periph_out <= 64'h0000_0000_0000_0001 << hot_periph;
    end
endmodule

// file: tb/rpsel_top_test.sv
// Purpose: Self-checking bench for the remappable pin select block.
// Assumes: APB answers in its own time; ce and byte lanes each exercised once.
// Notes: Peripheral inputs gathered as {clk,data,cts,rx,six,five,four,three}.
module rpsel_top_test;
    timeunit 1ns;
    timeprecision 100ps;

    logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic ce;
    logic [3:0] pstrb;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata;
    logic [63:0] remappable_pin, periph_out;
    logic [5:0] hot_pin, hot_periph;
    logic [7:0] in_vec;
    logic [3:0] pin_out, pin_oe_n;
    int miscompares = 0;
    int checks_done = 0;

    // --------------------------------------------------------------
    // Clock, reset, design and far side
    // --------------------------------------------------------------
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    rpsel_top dut_u (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .remappable_pin(remappable_pin), .periph_out(periph_out),
        .capture_channel_three(in_vec[0]), .capture_channel_four(in_vec[1]),
        .capture_channel_five(in_vec[2]), .capture_channel_six(in_vec[3]),
        .uart_four_receive(in_vec[4]), .uart_four_clear_to_send(in_vec[5]),
        .spi_three_data_in(in_vec[6]), .spi_three_clock_in(in_vec[7]),
        .remap_pin_out(pin_out), .remap_pin_oe_n(pin_oe_n));
    rpsel_far_model far_u (.pclk(pclk), .hot_pin(hot_pin), .hot_periph(hot_periph),
        .remappable_pin(remappable_pin), .periph_out(periph_out));

    // --------------------------------------------------------------
    // Tasks
    // --------------------------------------------------------------
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // One APB transfer; request held until pready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 50);
        if (n >= 50) miscompares++;
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic reg_wr(input int r, input logic [31:0] d);
        logic [31:0] rd;
        logic err;
        apb(1'b1, 8'(r * 4), d, rd, err);
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [31:0] exp, input logic exp_err);
        logic [31:0] rd;
        logic err;
        apb(1'b0, a, 32'h0000_0000, rd, err);
        check(rd, exp);
        check({31'h0, err}, {31'h0, exp_err});
    endtask

    task automatic end_of_test;
        $display("checks_done=%0d miscompares=%0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // --------------------------------------------------------------
    // Tests
    // --------------------------------------------------------------
    initial begin
        logic [5:0] osel [4];
        logic [3:0] exp_out, exp_oe;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        ce = 1'b1;
        pstrb = 4'hF;
        presetn = 1'b0;
        hot_pin = 6'h3F;
        hot_periph = 6'h00;
        repeat (20) @(posedge pclk);
        presetn <= 1'b1;
        // Reset state: nothing routed, no pin driven
        repeat (4) @(posedge pclk);
        check({24'h0, in_vec}, 32'h0000_0000);
        check({28'h0, pin_oe_n}, 32'h0000_000F);
        for (int r = 0; r < 6; r++) reg_rd(8'(r * 4), (r < 4) ? 32'h3F3F : 32'h0000, 1'b0);
        $display("test reset_values done");
        // Reserved bits ignore writes and read zero
        for (int r = 0; r < 6; r++) begin
            reg_wr(r, 32'hFFFF_FFFF);
            reg_rd(8'(r * 4), 32'h0000_3F3F, 1'b0);
            reg_wr(r, (r < 4) ? 32'h3F3F : 32'h0000);
        end
        reg_rd(8'h18, 32'h0000_0000, 1'b1);
        reg_rd(8'h02, 32'h0000_0000, 1'b1);
        $display("test reserved_bits done");
        // Input routing; each selector mapped before its input is used
        for (int r = 0; r < 4; r++) begin
            reg_wr(r, {18'h0, 6'(r * 9), 2'b00, 6'(62 - r)});
            hot_pin <= 6'(r * 9);
            repeat (5) @(posedge pclk);
            check({24'h0, in_vec}, 32'(1 << (2 * r + 1)));
            hot_pin <= 6'(62 - r);
            repeat (5) @(posedge pclk);
            check({24'h0, in_vec}, 32'(1 << (2 * r)));
        end
        $display("test input_routing done");
        // Only the enabled byte lane of a write lands
        pstrb <= 4'h2;
        reg_wr(0, 32'h0000_2A15);
        pstrb <= 4'hF;
        reg_rd(8'h00, 32'h0000_2A3E, 1'b0);
        $display("test byte_lanes done");
        // Output routing, including the null number zero
        osel = '{6'h3F, 6'h01, 6'h21, 6'h00};
        reg_wr(4, {18'h0, osel[1], 2'b00, osel[0]});
        reg_wr(5, {18'h0, osel[3], 2'b00, osel[2]});
        foreach (osel[h]) begin
            hot_periph <= osel[h];
            repeat (4) @(posedge pclk);
            for (int p = 0; p < 4; p++) begin
                exp_oe[p] = (osel[p] == 6'h00);
                exp_out[p] = (osel[p] != 6'h00) && (osel[p] == osel[h]);
            end
            check({28'h0, pin_oe_n}, {28'h0, exp_oe});
            check({28'h0, pin_out}, {28'h0, exp_out});
        end
        reg_rd(8'h10, 32'h0000_013F, 1'b0);
        reg_rd(8'h14, 32'h0000_0021, 1'b0);
        $display("test output_routing done");
        // Clock enable low freezes the routing flops
        ce <= 1'b0;
        hot_periph <= osel[1];
        repeat (4) @(posedge pclk);
        check({28'h0, pin_out}, 32'h0000_0000);
        ce <= 1'b1;
        repeat (4) @(posedge pclk);
        check({28'h0, pin_out}, 32'h0000_0002);
        $display("test clock_enable done");
        end_of_test();
    end

    // Watchdog: the tests need a few hundred cycles at most
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        end_of_test();
    end
endmodule
